// ---- cmsq_sequencer.v ----
// Purpose: mode control and measurement sequencing of a capacitive sensor conditioner
// Assumes: converter sample is valid on ADC_RESULT when a step ends
// Notes: registers reached over AHB-Lite; config words load from nonvolatile defaults
// Operation
// R1 - idle low power after command, keep listening
// R2 - sleep mode: wake, execute, publish, sleep
// R3 - power-on: core on, load config, sleep
// R4 - cyclic wake after interval from word 02
// R5 - command mode only if first command
// R6 - command mode stays active until normal command
// R7 - command mode accepts all; measures on request (the cyclic opcode is ignored while in command mode)
// R8 - route sensor pin per word 19 field
// R9 - single-ended grounds the reference electrode
// R10 - noise bit selects amplifier bias current
// R11 - multiplexer picks sensor or temperature input
// R12 - full request runs every step automatically
// R13 - sensor resolution programmable 12 to 18
// R14 - temperature always converted at 14 bits
// R15 - conversion: autozero, sensor, temperature, math
// R16 - math applies autozero, span, temperature terms
// R17 - cyclic mode drives density modulated output
// R18 - resolution field in word 12, default 16
// R19 - type bit clear differential, set single-ended
// R20 - saturate overflow and flag in status
// R21 - reset defaults to normal sleep mode
// R22 - late enter-command opcode changes nothing
`timescale 1ns/10ps
`include "cmsq_defines.vh"
module cmsq_sequencer #(
   parameter SLEEP_UNIT_CYC = `CMSQ_SLEEP_UNIT_CYC,
   parameter STEP_BASE_CYC = `CMSQ_STEP_BASE_CYC,
   parameter [15:0] NVM_CFG02 = 16'h1000,
   parameter [15:0] NVM_CFG12 = 16'h0080,
   parameter [15:0] NVM_CFG19 = 16'h0001,
   parameter [15:0] NVM_SPAN = 16'h4000,
   parameter [31:0] NVM_TCOEF = 32'h0000_0000
) (
   input wire SYS_CLK,
   input wire RESETN,
   input wire HSEL,
   input wire [7:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output reg [31:0] HRDATA,
   output reg HREADYOUT,
   output reg HRESP,
   input wire [17:0] ADC_RESULT,
   output reg CORE_POWER_EN,
   output reg [1:0] SENSOR_PIN_SELECT,
   output reg REF_ELECTRODE_GND,
   output reg BIAS_HIGH,
   output reg MUX_TEMP,
   output reg [4:0] ADC_BITS,
   output reg PDM_OUT,
   output reg BUSY
);

   // ****************************************************************
   // states
   // ****************************************************************
   localparam [2:0] ST_BOOT = 3'h0; // core domain on, loading config
   localparam [2:0] ST_SLEEP = 3'h1; // core off, bus still listening
   localparam [2:0] ST_ACTIVE = 3'h2; // command mode, core kept on
   localparam [2:0] ST_AZ = 3'h3; // auto-zero step
   localparam [2:0] ST_SENS = 3'h4; // sensor step
   localparam [2:0] ST_TEMP = 3'h5; // temperature step
   localparam [2:0] ST_MATH = 3'h6; // correction and publish

   reg [2:0] state; // sequencer state
   reg [15:0] boot_count; // boot load timer
   reg cmd_mode; // command mode latched
   reg first_cmd; // no command seen since reset
   reg cyclic; // cyclic normal operation
   reg [31:0] sleep_count; // cyclic wake timer
   reg [15:0] cfg02; // loaded configuration words
   reg [15:0] cfg12;
   reg [15:0] cfg19;
   reg [15:0] span; // span coefficient
   reg [31:0] tcoef; // first order low, second order high
   reg [17:0] az_raw; // captured samples
   reg [17:0] sens_raw;
   reg [17:0] temp_raw;
   reg [23:0] sens_out; // corrected sensor value
   reg saturated; // last result clipped
   reg [16:0] pdm_acc; // density modulator accumulator
   reg step_start; // pulse to the step timer
   reg rd_pend; // read waiting for its data cycle
   reg [7:0] ph_addr; // data phase address
   reg ph_write; // data phase is a write
   wire step_done; // step timer finished
   wire addr_ok; // valid address phase
   wire wr_fire; // write lands this cycle
   wire [7:0] op; // written opcode
   reg [31:0] rd_mux; // read data selection
   reg [47:0] math_sum; // correction result before clipping
   wire [24:0] sat_res; // clipped result, clip flag on top

   // ****************************************************************
   // helpers
   // ****************************************************************
   // clip a wide signed value into the output range
   function [24:0] cmsq_sat;
      input [47:0] v;
      begin
         if ($signed(v) > $signed({24'h0, `CMSQ_OUT_MAX}))
            cmsq_sat = {1'b1, `CMSQ_OUT_MAX};
         else if ($signed(v) < $signed({{24{1'b1}}, `CMSQ_OUT_MIN}))
            cmsq_sat = {1'b1, `CMSQ_OUT_MIN};
         else
            cmsq_sat = {1'b0, v[23:0]};
      end
   endfunction

   // resolution code to bit count
   function [4:0] cmsq_bits;
      input [1:0] code;
      begin
         cmsq_bits = `CMSQ_RES_MIN_BITS + {2'h0, code, 1'b0};
      end
   endfunction

   assign addr_ok = HSEL & HTRANS[1] & HREADY;
   assign wr_fire = ph_write;
   assign op = HWDATA[7:0];
   assign sat_res = cmsq_sat(math_sum); // R20

   // ****************************************************************
   // step timer
   // ****************************************************************
   cmsq_step_timer #(
      .BASE_CYC(STEP_BASE_CYC)
   ) u_timer (
      .clk(SYS_CLK),
      .resetn(RESETN),
      .start(step_start),
      .res_code((state == ST_TEMP) ? `CMSQ_TEMP_RES : cfg12[`CMSQ_ADCB_HI:`CMSQ_ADCB_LO]), // R14
      .done(step_done)
   );

   // ****************************************************************
   // correction math
   // ****************************************************************
   // fixed point terms; wide sum keeps overflow visible for clipping
   always @* begin
      math_sum = 48'h0;
      math_sum = (($signed({30'h0, sens_raw}) - $signed({30'h0, az_raw}))
         * $signed({{32{span[15]}}, span})) >>> `CMSQ_COEF_SHIFT; // R16
      math_sum = $signed(math_sum) + ((($signed({30'h0, temp_raw}) - $signed({30'h0, az_raw}))
         * $signed({{32{tcoef[15]}}, tcoef[15:0]})) >>> `CMSQ_COEF_SHIFT); // R16
      math_sum = $signed(math_sum) + (($signed({30'h0, temp_raw}) * $signed({30'h0, temp_raw})
         * $signed({{32{tcoef[31]}}, tcoef[31:16]})) >>> (2 * `CMSQ_COEF_SHIFT)); // R16
   end

   // ****************************************************************
   // bus slave
   // ****************************************************************
   // reads take one wait cycle so a write just before is seen
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         HRDATA <= 32'h0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
         rd_pend <= 1'b0;
         ph_addr <= 8'h0;
         ph_write <= 1'b0;
      end else begin
         HRESP <= 1'b0; // always okay
         ph_write <= 1'b0;
         rd_pend <= 1'b0;
         if (rd_pend) begin
            HRDATA <= rd_mux;
            HREADYOUT <= 1'b1;
         end else if (addr_ok) begin
            ph_addr <= HADDR;
            ph_write <= HWRITE;
            if (!HWRITE) begin
               rd_pend <= 1'b1;
               HREADYOUT <= 1'b0;
            end
         end
      end
   end

   // read selection; unmapped offsets read zero
   always @* begin
      rd_mux = 32'h0;
      case (ph_addr)
         `CMSQ_ADDR_CFG02: rd_mux = {16'h0, cfg02};
         `CMSQ_ADDR_CFG12: rd_mux = {16'h0, cfg12};
         `CMSQ_ADDR_CFG19: rd_mux = {16'h0, cfg19};
         `CMSQ_ADDR_STATUS: rd_mux = {24'h0, saturated, cyclic, first_cmd, cmd_mode,
            BUSY, state}; // R20
         `CMSQ_ADDR_SENSOR: rd_mux = {8'h0, sens_out};
         `CMSQ_ADDR_TEMP: rd_mux = {14'h0, temp_raw};
         `CMSQ_ADDR_SPAN: rd_mux = {16'h0, span};
         `CMSQ_ADDR_TCOEF: rd_mux = tcoef;
         default: rd_mux = 32'h0;
      endcase
   end

   // ****************************************************************
   // mode and measurement sequencer
   // ****************************************************************
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state <= ST_BOOT;
         boot_count <= 16'h0;
         cmd_mode <= 1'b0; // R21
         first_cmd <= 1'b1;
         cyclic <= 1'b0;
         sleep_count <= 32'h0;
         cfg02 <= 16'h0;
         cfg12 <= 16'h0;
         cfg19 <= 16'h0;
         span <= 16'h0;
         tcoef <= 32'h0;
         az_raw <= 18'h0;
         sens_raw <= 18'h0;
         temp_raw <= 18'h0;
         sens_out <= 24'h0;
         saturated <= 1'b0;
         step_start <= 1'b0;
      end else begin
         step_start <= 1'b0;
         // configuration writes accepted in command mode only
         if (wr_fire && cmd_mode) begin
            case (ph_addr)
               `CMSQ_ADDR_CFG02: cfg02 <= HWDATA[15:0];
               `CMSQ_ADDR_CFG12: cfg12 <= HWDATA[15:0];
               `CMSQ_ADDR_CFG19: cfg19 <= HWDATA[15:0];
               `CMSQ_ADDR_SPAN: span <= HWDATA[15:0];
               `CMSQ_ADDR_TCOEF: tcoef <= HWDATA;
               default: ;
            endcase
         end
         case (state)
            ST_BOOT: begin
               // load interface config, then power down
               if (boot_count == `CMSQ_BOOT_LOAD_CYC - 1) begin
                  cfg02 <= NVM_CFG02; // R3
                  cfg12 <= NVM_CFG12;
                  cfg19 <= NVM_CFG19;
                  span <= NVM_SPAN;
                  tcoef <= NVM_TCOEF;
                  state <= ST_SLEEP; // R3
               end else begin
                  boot_count <= boot_count + 16'h1;
               end
            end
            ST_SLEEP, ST_ACTIVE: begin
               if (wr_fire && ph_addr == `CMSQ_ADDR_CMD) begin
                  // any written opcode ends the first-command window
                  first_cmd <= 1'b0;
                  case (op)
                     `CMSQ_OP_ENTER_CM: begin
                        if (first_cmd) begin
                           cmd_mode <= 1'b1; // R5
                           cyclic <= 1'b0;
                           state <= ST_ACTIVE; // R6
                        end // R22
                     end
                     `CMSQ_OP_BEGIN_NOM: begin
                        cmd_mode <= 1'b0;
                        state <= ST_SLEEP; // R6
                     end
                     `CMSQ_OP_MEASURE: begin
                        state <= ST_AZ; // R2 R7 R12
                        step_start <= 1'b1;
                     end
                     `CMSQ_OP_CYCLIC: begin
                        if (!cmd_mode) begin
                           cyclic <= 1'b1;
                           state <= ST_AZ; // R4
                           step_start <= 1'b1;
                        end
                     end
                     default: ;
                  endcase
               end else if (state == ST_SLEEP && cyclic) begin
                  // autonomous wake after the selected interval
                  if (sleep_count == 32'h0) begin
                     state <= ST_AZ; // R4
                     step_start <= 1'b1;
                  end else begin
                     sleep_count <= sleep_count - 32'h1;
                  end
               end
            end
            ST_AZ: begin
               if (step_done) begin
                  az_raw <= ADC_RESULT; // R15
                  state <= ST_SENS;
                  step_start <= 1'b1;
               end
            end
            ST_SENS: begin
               if (step_done) begin
                  sens_raw <= ADC_RESULT; // R15
                  state <= ST_TEMP;
                  step_start <= 1'b1;
               end
            end
            ST_TEMP: begin
               if (step_done) begin
                  temp_raw <= ADC_RESULT; // R15
                  state <= ST_MATH;
               end
            end
            ST_MATH: begin
               sens_out <= sat_res[23:0]; // R16
               saturated <= sat_res[24]; // R20
               sleep_count <= (SLEEP_UNIT_CYC << cfg02[`CMSQ_CYC_HI:`CMSQ_CYC_LO]) - 1; // R4
               state <= cmd_mode ? ST_ACTIVE : ST_SLEEP; // R1 R2 R6
            end
            default: state <= ST_SLEEP;
         endcase
      end
   end

   // ****************************************************************
   // analog controls, all registered
   // ****************************************************************
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         CORE_POWER_EN <= 1'b0;
         SENSOR_PIN_SELECT <= 2'h0;
         REF_ELECTRODE_GND <= 1'b0;
         BIAS_HIGH <= 1'b0;
         MUX_TEMP <= 1'b0;
         ADC_BITS <= 5'h0;
         BUSY <= 1'b0;
      end else begin
         CORE_POWER_EN <= (state != ST_SLEEP); // R1 R3
         SENSOR_PIN_SELECT <= cfg19[`CMSQ_PIN_HI:`CMSQ_PIN_LO]; // R8
         REF_ELECTRODE_GND <= cfg12[`CMSQ_SETYPE_BIT]; // R9 R19
         BIAS_HIGH <= cfg12[`CMSQ_NOISE_BIT]; // R10
         MUX_TEMP <= (state == ST_TEMP); // R11
         ADC_BITS <= (state == ST_TEMP) ? cmsq_bits(`CMSQ_TEMP_RES) :
            cmsq_bits(cfg12[`CMSQ_ADCB_HI:`CMSQ_ADCB_LO]); // R13 R14 R18
         BUSY <= (state >= ST_AZ) || (state == ST_BOOT);
      end
   end

   // ****************************************************************
   // density modulated output
   // ****************************************************************
   // first order modulator on the top 16 bits, offset to unsigned
   always @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pdm_acc <= 17'h0;
         PDM_OUT <= 1'b0;
      end else if (cyclic && !cmd_mode) begin
         pdm_acc <= {1'b0, pdm_acc[15:0]} + {1'b0, ~sens_out[23], sens_out[22:8]}; // R17
         PDM_OUT <= pdm_acc[16]; // R17
      end else begin
         pdm_acc <= 17'h0;
         PDM_OUT <= 1'b0;
      end
   end
endmodule

// ---- cmsq_defines.vh ----
// Purpose: shared constants of the capacitive sensor mode sequencer
// Assumes: 32-bit AHB-Lite register bus, word aligned registers
// Notes: definitions only, no logic
`ifndef CMSQ_DEFINES_VH
`define CMSQ_DEFINES_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CMSQ_ADDR_CMD 8'h00
`define CMSQ_ADDR_CFG02 8'h04
`define CMSQ_ADDR_CFG12 8'h08
`define CMSQ_ADDR_CFG19 8'h0C
`define CMSQ_ADDR_STATUS 8'h10
`define CMSQ_ADDR_SENSOR 8'h14
`define CMSQ_ADDR_TEMP 8'h18
`define CMSQ_ADDR_SPAN 8'h1C
`define CMSQ_ADDR_TCOEF 8'h20

// ****************************************************************
// command opcodes
// ****************************************************************
`define CMSQ_OP_ENTER_CM 8'hA9
`define CMSQ_OP_BEGIN_NOM 8'hA8
`define CMSQ_OP_MEASURE 8'hAA
`define CMSQ_OP_CYCLIC 8'hAB

// ****************************************************************
// configuration word fields
// ****************************************************************
`define CMSQ_CYC_HI 14
`define CMSQ_CYC_LO 12
`define CMSQ_ADCB_HI 7
`define CMSQ_ADCB_LO 6
`define CMSQ_NOISE_BIT 8
`define CMSQ_SETYPE_BIT 15
`define CMSQ_PIN_HI 1
`define CMSQ_PIN_LO 0

// ****************************************************************
// resolution codes and bit counts
// ****************************************************************
`define CMSQ_RES_12 2'h0
`define CMSQ_RES_14 2'h1
`define CMSQ_RES_16 2'h2
`define CMSQ_RES_MIN_BITS 5'h0C
`define CMSQ_TEMP_RES `CMSQ_RES_14

// ****************************************************************
// timing (figures in their own unit, cycles derived)
// ****************************************************************
`define CMSQ_CLK_MHZ 200
`define CMSQ_SLEEP_UNIT_US 1000
`define CMSQ_SLEEP_UNIT_CYC (`CMSQ_SLEEP_UNIT_US * `CMSQ_CLK_MHZ)
`define CMSQ_BOOT_LOAD_NS 400
`define CMSQ_BOOT_LOAD_CYC ((`CMSQ_BOOT_LOAD_NS * `CMSQ_CLK_MHZ + 999) / 1000)
`define CMSQ_STEP_BASE_CYC 64

// ****************************************************************
// math
// ****************************************************************
`define CMSQ_COEF_SHIFT 14
`define CMSQ_OUT_MAX 24'h7FFFFF
`define CMSQ_OUT_MIN 24'h800000

`endif

// ---- cmsq_step_timer.v ----
// Purpose: times one converter step at the selected resolution
// Assumes: start is a one-cycle pulse while idle
// Notes: each two extra bits of resolution quadruple the step length
`timescale 1ns/10ps
module cmsq_step_timer #(
   parameter BASE_CYC = 64
) (
   input wire clk,
   input wire resetn,
   input wire start,
   input wire [1:0] res_code,
   output reg done
);
`include "cmsq_defines.vh"

   reg [31:0] count; // cycles left in the running step
   reg running; // a step is in progress

   // ****************************************************************
   // step counter
   // ****************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count <= 32'h0;
         running <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !running) begin
            // length grows fourfold per resolution code
            count <= (BASE_CYC << {res_code, 1'b0}) - 1;
            running <= 1'b1;
         end else if (running) begin
            if (count == 32'h0) begin
               running <= 1'b0;
               done <= 1'b1;
            end else begin
               count <= count - 32'h1;
            end
         end
      end
   end
endmodule

// ---- cmsq_monitor.sv ----
// Purpose: port checks on the capacitive sensor mode sequencer
// Assumes: one clock domain, asynchronous active low reset
// Notes: bound to every sequencer instance at the foot of this file
`timescale 1ns/10ps
module cmsq_monitor (
   input wire SYS_CLK,
   input wire RESETN,
   input wire HSEL,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire HREADY,
   input wire HREADYOUT,
   input wire HRESP,
   input wire CORE_POWER_EN,
   input wire MUX_TEMP,
   input wire [4:0] ADC_BITS,
   input wire BUSY
);
   // ****************************************************************
   // bus and sequencing properties
   // ****************************************************************
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RESETN);
   // address phase accepted by the slave
   wire taken = HSEL & HTRANS[1] & HREADY;
   // boot keeps the core domain up and reports busy
   sequence boot_hold;
      (BUSY && CORE_POWER_EN) [*8];
   endsequence
   // a read data phase stalls exactly one cycle
   sequence read_wait;
      !HREADYOUT ##1 HREADYOUT;
   endsequence
   a_resp_okay: assert property (HRESP == 1'b0)
      else $error("error response driven");
   a_read_wait: assert property (taken && !HWRITE |-> ##1 read_wait)
      else $error("read wait state not exactly one");
   a_write_nowait: assert property (taken && HWRITE |-> ##1 HREADYOUT)
      else $error("write data phase stalled");
   a_boot_busy: assert property ($rose(RESETN) |-> ##2 boot_hold)
      else $error("boot does not hold core power");
   a_boot_sleep: assert property ($rose(RESETN) |-> ##[70:90] !CORE_POWER_EN)
      else $error("no sleep after boot");
   a_temp_bits: assert property (MUX_TEMP |-> ADC_BITS == 5'h0E)
      else $error("temperature step not at fourteen bits");
   // the first edge after release still shows the reset value of the resolution
   a_sensor_bits: assert property ($past(RESETN) && !BUSY |->
      ADC_BITS inside {5'h0C, 5'h0E, 5'h10, 5'h12})
      else $error("sensor resolution out of range");
   a_mux_busy: assert property (MUX_TEMP |-> BUSY && CORE_POWER_EN)
      else $error("temperature input outside a measurement");
   a_busy_power: assert property (BUSY |-> CORE_POWER_EN)
      else $error("busy while core domain is off");
   a_measure_end: assert property ($rose(BUSY) |-> ##[1:1000] !BUSY)
      else $error("measurement sequence does not finish");
endmodule

bind cmsq_sequencer cmsq_monitor mon (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .HSEL(HSEL),
   .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
   .HRESP(HRESP), .CORE_POWER_EN(CORE_POWER_EN), .MUX_TEMP(MUX_TEMP),
   .ADC_BITS(ADC_BITS), .BUSY(BUSY));

// ---- cmsq_host_model.sv ----
// Purpose: bus host that issues commands and reads results
// Assumes: tasks are entered just after a rising clock edge
// Notes: single word transfers only, waits for ready without a cycle count
`timescale 1ns/10ps
module cmsq_host_model (
   input wire clk,
   input wire hready,
   input wire [31:0] hrdata,
   output logic hsel,
   output logic [7:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   // idle bus at time zero
   initial begin
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // one transfer: address phase held until ready, then data phase
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
      // released data must not keep showing the last word
      hwdata <= ~d;
   endtask
endmodule

// ---- tb.sv ----
// Purpose: self-checking bench of the mode sequencer
// Assumes: short sleep unit and step base to keep the run brief
// Notes: a queue of sent opcodes models the command mode window
`timescale 1ns/10ps
`include "cmsq_defines.vh"
module tb;
   logic clk;
   logic rst_n;
   logic [17:0] adc;
   wire hsel, hwrite, hready, hresp, core_en, ref_gnd, bias_hi, mux_t, pdm, busy;
   wire [7:0] haddr;
   wire [1:0] htrans, pin_sel;
   wire [2:0] hsize;
   wire [31:0] hwdata, hrdata;
   wire [4:0] adc_bits;
   int mismatches, compares, cm, code, pin, f, gap, seen_t, ones;
   int ops[$]; // opcodes since the last reset
   logic [31:0] rd;
   logic [17:0] lvl;
   cmsq_sequencer #(.SLEEP_UNIT_CYC(8), .STEP_BASE_CYC(4)) dut (.SYS_CLK(clk),
      .RESETN(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
      .HRESP(hresp), .ADC_RESULT(adc), .CORE_POWER_EN(core_en), .SENSOR_PIN_SELECT(pin_sel),
      .REF_ELECTRODE_GND(ref_gnd), .BIAS_HIGH(bias_hi), .MUX_TEMP(mux_t),
      .ADC_BITS(adc_bits), .PDM_OUT(pdm), .BUSY(busy));
   cmsq_host_model host (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   // ****************************************************************
   // helpers
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task rd_reg(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, rd);
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd);
   endtask
   // wait out a measurement, noting whether the temperature input was used
   task settle;
      seen_t = 0;
      repeat (2) @(posedge clk);
      while (busy === 1'b1) begin
         if (mux_t === 1'b1) seen_t = 1;
         @(posedge clk);
      end
   endtask
   // only the very first opcode after reset may open command mode
   task cmd(input logic [7:0] op);
      wr_reg(`CMSQ_ADDR_CMD, {24'h0, op});
      ops.push_back(op);
      if (ops.size() == 1 && op == `CMSQ_OP_ENTER_CM) cm = 1;
      if (op == `CMSQ_OP_BEGIN_NOM) cm = 0;
      settle();
   endtask
   task check_status;
      rd_reg(`CMSQ_ADDR_STATUS);
      chk(rd[2:0], cm ? 2 : 1);
      chk(rd[4], cm);
      chk(core_en, cm);
   endtask
   task do_reset;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      ops.delete();
      cm = 0;
      repeat (3) @(posedge clk);
      chk(busy, 1);
      chk(core_en, 1);
      do rd_reg(`CMSQ_ADDR_STATUS); while (rd[2:0] !== 3'h1);
      check_status();
   endtask
   // ****************************************************************
   // main sequence and watchdog
   // ****************************************************************
   initial begin
      rst_n = 1'b0;
      adc = 18'h0;
      mismatches = 0;
      compares = 0;
      cm = 0;
      void'($urandom(50277));
      @(posedge clk);
      do_reset();
      chk(adc_bits, 16);
      chk(ref_gnd, 0);
      chk(pin_sel, 1);
      chk(bias_hi, 0);
      wr_reg(`CMSQ_ADDR_CFG12, 32'h8100);
      rd_reg(`CMSQ_ADDR_CFG12);
      chk(rd[15:0], 16'h0080);
      rd_reg(8'h3C);
      chk(rd, 0);
      rd_reg(`CMSQ_ADDR_CMD);
      chk(rd, 0);
      cmd(`CMSQ_OP_MEASURE);
      chk(seen_t, 1);
      check_status();
      cmd(`CMSQ_OP_ENTER_CM);
      check_status();
      do_reset();
      cmd(`CMSQ_OP_ENTER_CM);
      check_status();
      code = $urandom % 4;
      pin = $urandom % 4;
      f = $urandom % 3;
      lvl = 18'($urandom);
      wr_reg(`CMSQ_ADDR_CFG12, 32'h8100 | (code << 6));
      wr_reg(`CMSQ_ADDR_CFG19, pin);
      wr_reg(`CMSQ_ADDR_CFG02, f << 12);
      repeat (2) @(posedge clk);
      chk(ref_gnd, 1);
      chk(bias_hi, 1);
      chk(adc_bits, 12 + 2 * code);
      chk(pin_sel, pin);
      chk(pdm, 0);
      adc <= lvl;
      cmd(`CMSQ_OP_MEASURE);
      chk(seen_t, 1);
      check_status();
      rd_reg(`CMSQ_ADDR_TEMP);
      chk(rd[17:0], lvl);
      rd_reg(`CMSQ_ADDR_SENSOR);
      chk(rd[23:0], 0);
      cmd(`CMSQ_OP_CYCLIC);
      rd_reg(`CMSQ_ADDR_STATUS);
      chk(rd[6], 0);
      cmd(`CMSQ_OP_BEGIN_NOM);
      check_status();
      cmd(`CMSQ_OP_CYCLIC);
      rd_reg(`CMSQ_ADDR_STATUS);
      chk(rd[6], 1);
      // first sleep is partly spent on the status read, so only later ones count
      // a zero result modulates at half density: ones and zeros alternate
      for (int i = 0; i < 3; i++) begin
         settle();
         gap = 0;
         ones = 0;
         while (busy !== 1'b1) begin
            gap++;
            if (pdm === 1'b1) ones++;
            @(posedge clk);
         end
         if (i > 0) chk(gap >= (8 << f) - 2 && gap <= (8 << f) + 4, 1);
         if (i > 0) chk(ones * 2 >= gap - 2 && ones * 2 <= gap + 2, 1);
      end
      test_done();
   end
   // generous span: two boots and a handful of measurements
   initial begin
      #100000;
      mismatches++;
      test_done();
   end
endmodule
